// ==== gofm_pkg.sv ====
package gofm_pkg;
  localparam int GOFM_NPIN = 7;
  localparam int GOFM_NPORT = 2;
  localparam int GOFM_NFWD = 4;
  // APB register map, pin config registers one byte apart, others one word apart
  localparam logic [7:0] GOFM_PIN_CFG_BASE = 8'h10;
  localparam logic [7:0] GOFM_PIN_CFG_LAST = 8'h16;
  localparam logic [7:0] GOFM_LINK_CNT0_ADDR = 8'h40;
  localparam logic [7:0] GOFM_LINK_CNT1_ADDR = 8'h44;
  localparam logic [7:0] GOFM_PORT_EN_ADDR = 8'h48;
  localparam logic [7:0] GOFM_PIN_STAT_ADDR = 8'h4C;
  // pin_output_config field positions
  localparam int GOFM_EN_BIT = 0;
  localparam int GOFM_VAL_BIT = 1;
  localparam int GOFM_SRC_LSB = 2;
  localparam int GOFM_FUN_LSB = 5;
  localparam logic [7:0] GOFM_PIN_CFG_RST = 8'h00;
  localparam logic [2:0] GOFM_LINK_CNT_RST = 3'h1;
  localparam logic [1:0] GOFM_PORT_EN_RST = 2'h3;
  // Source codes
  localparam logic [2:0] GOFM_SRC_PORT0 = 3'h0;
  localparam logic [2:0] GOFM_SRC_PORT1 = 3'h1;
  localparam logic [2:0] GOFM_SRC_DEV = 3'h4;
  localparam logic [2:0] GOFM_SRC_CSI = 3'h5;
  // Forward frames per sample, by linked count
  localparam logic [2:0] GOFM_FRAMES_ONE = 3'h1;
  localparam logic [2:0] GOFM_FRAMES_TWO = 3'h2;
  localparam logic [2:0] GOFM_FRAMES_MANY = 3'h5;
  // Timing at pclk 10 MHz
  localparam int GOFM_CLK_PERIOD_NS = 100;
  localparam int GOFM_FWD_LAT_NS = 225;
  localparam int GOFM_FWD_LAT_CYC = (GOFM_FWD_LAT_NS + GOFM_CLK_PERIOD_NS - 1) / GOFM_CLK_PERIOD_NS;
  localparam int GOFM_SYNC_STAGES = 3;
endpackage

// ==== gofm_cfg_mem.sv ====
`timescale 1ns/100ps
// Seven pin config words with registered read
module gofm_cfg_mem
  import gofm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic [2:0] rd_idx,
  output logic [7:0] rd_data_r,
  output logic [GOFM_NPIN*8-1:0] cfg_flat
);
  logic [7:0] mem_r [GOFM_NPIN];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < GOFM_NPIN; i++) begin
        mem_r[i] <= GOFM_PIN_CFG_RST;
      end
    end else if (ce && wr_en && (int'(wr_idx) < GOFM_NPIN)) begin
      mem_r[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data_r <= 8'h00;
    end else if (ce) begin
      rd_data_r <= (int'(rd_idx) < GOFM_NPIN) ? mem_r[rd_idx] : 8'h00;
    end
  end

  always_comb begin
    for (int i = 0; i < GOFM_NPIN; i++) begin
      cfg_flat[i*8 +: 8] = mem_r[i];
    end
  end
endmodule

// ==== gofm_top.sv ====
`timescale 1ns/100ps
// Behaviour
// R01: Static source drives stored level bit
// R02: Lock OR / AND over enabled ports
// R03: AND of pass over enabled ports
// R04: Frame sync pulse on code 100
// R05: Device interrupt high or inverted
// R06: CSI pass AND / OR selected ports
// R07: Recovered frame valid and line valid
// R08: Both ports synchronized indication
// R09: CSI transmit interrupt active high
// R10: Seven independently configured output pins
// R11: Up to four forward values per port
// R12: Any forward value routable to any pin
// R13: Update every 1, 2 or 5 frames
// R14: Forward latency about 225 ns; code takes at least five pclk edges, 500 ns
// R15: Remote toggles at most quarter rate
// R16: Only newer serializer sends forward values
// R17: Port sources select forward, lock, pass, valid
// R18: Drive enable low gives no output
// R19: Software clears input enable first
// R20: Reserved combinations leave pin undriven
module gofm_top
  import gofm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] fwd_gpio_p0,
  input wire logic [3:0] fwd_gpio_p1,
  input wire logic [1:0] fwd_frame_strobe,
  input wire logic [1:0] port_lock,
  input wire logic [1:0] port_pass,
  input wire logic [1:0] port_frame_valid,
  input wire logic [1:0] port_line_valid,
  input wire logic frame_sync_pulse,
  input wire logic dev_irq,
  input wire logic csi_frame_valid,
  input wire logic csi_line_valid,
  input wire logic ports_synced,
  input wire logic csi_irq,
  output logic [GOFM_NPIN-1:0] gpio_out,
  output logic [GOFM_NPIN-1:0] gpio_oe_n
);
  typedef enum logic [1:0] {GOFM_IDLE = 2'b00, GOFM_ACCESS = 2'b01, GOFM_DONE = 2'b11} gofm_state_t;

  gofm_state_t state_r;
  logic [2:0] link_cnt_r [GOFM_NPORT];
  logic [1:0] port_en_r;
  logic [GOFM_NPIN*8-1:0] cfg_flat;
  logic [7:0] cfg_rd;
  logic [3:0] fwd_s1_r [GOFM_NPORT];
  logic [3:0] fwd_s2_r [GOFM_NPORT];
  logic [3:0] fwd_s3_r [GOFM_NPORT];
  logic [3:0] fwd_hold_r [GOFM_NPORT];
  logic [2:0] frame_cnt_r [GOFM_NPORT];
  logic [GOFM_NPIN-1:0] pin_val;
  logic [GOFM_NPIN-1:0] pin_drv;
  logic is_cfg;
  logic wr_fire;
  logic [2:0] cfg_idx;

  function automatic logic [2:0] frames_per_sample(input logic [2:0] cnt);
    if (cnt <= 3'h1) begin
      return GOFM_FRAMES_ONE;
    end else if (cnt == 3'h2) begin
      return GOFM_FRAMES_TWO;
    end
    return GOFM_FRAMES_MANY;
  endfunction

  function automatic logic and_enabled(input logic [1:0] v, input logic [1:0] en);
    return (en != 2'b00) && ((v & en) == en);
  endfunction

  assign is_cfg = (paddr >= GOFM_PIN_CFG_BASE) && (paddr <= GOFM_PIN_CFG_LAST);
  assign cfg_idx = 3'(paddr - GOFM_PIN_CFG_BASE);
  assign wr_fire = psel && penable && pwrite && (state_r == GOFM_ACCESS);

  // R10: seven pin words
  gofm_cfg_mem u_cfg (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .wr_en(wr_fire && is_cfg),
    .wr_idx(cfg_idx),
    .wr_data(pwdata[7:0]),
    .rd_idx(cfg_idx),
    .rd_data_r(cfg_rd),
    .cfg_flat(cfg_flat)
  );

  // Setup cycle loads the registered read, access answers next edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= GOFM_IDLE;
      pready <= 1'b0;
    end else if (ce) begin
      unique case (state_r)
        GOFM_IDLE: begin
          pready <= 1'b0;
          if (psel && !penable) begin
            state_r <= GOFM_ACCESS;
          end
        end
        GOFM_ACCESS: begin
          if (psel && penable) begin
            state_r <= GOFM_DONE;
            pready <= 1'b1;
          end
        end
        GOFM_DONE: begin
          state_r <= GOFM_IDLE;
          pready <= 1'b0;
        end
        default: begin
          state_r <= GOFM_IDLE;
          pready <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce && psel && penable && state_r == GOFM_ACCESS) begin
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (is_cfg) begin
        prdata <= {24'h00_0000, cfg_rd};
      end else if (paddr == GOFM_LINK_CNT0_ADDR) begin
        prdata <= {29'h0, link_cnt_r[0]};
      end else if (paddr == GOFM_LINK_CNT1_ADDR) begin
        prdata <= {29'h0, link_cnt_r[1]};
      end else if (paddr == GOFM_PORT_EN_ADDR) begin
        prdata <= {30'h0, port_en_r};
      end else if (paddr == GOFM_PIN_STAT_ADDR) begin
        prdata <= {17'h0, ~gpio_oe_n, 1'b0, gpio_out};
      end else begin
        pslverr <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_cnt_r[0] <= GOFM_LINK_CNT_RST;
      link_cnt_r[1] <= GOFM_LINK_CNT_RST;
      port_en_r <= GOFM_PORT_EN_RST;
    end else if (ce && wr_fire) begin
      if (paddr == GOFM_LINK_CNT0_ADDR) begin
        link_cnt_r[0] <= pwdata[2:0];
      end
      if (paddr == GOFM_LINK_CNT1_ADDR) begin
        link_cnt_r[1] <= pwdata[2:0];
      end
      if (paddr == GOFM_PORT_EN_ADDR) begin
        port_en_r <= pwdata[1:0];
      end
    end
  end

  // Forward values and strobes come from the link domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < GOFM_NPORT; p++) begin
        fwd_s1_r[p] <= 4'h0;
        fwd_s2_r[p] <= 4'h0;
        fwd_s3_r[p] <= 4'h0;
      end
    end else if (ce) begin
      fwd_s1_r[0] <= fwd_gpio_p0;
      fwd_s1_r[1] <= fwd_gpio_p1;
      for (int p = 0; p < GOFM_NPORT; p++) begin
        fwd_s2_r[p] <= fwd_s1_r[p];
        fwd_s3_r[p] <= fwd_s2_r[p];
      end
    end
  end

  logic [1:0] stb_s1_r, stb_s2_r, stb_s3_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stb_s1_r <= 2'b00;
      stb_s2_r <= 2'b00;
      stb_s3_r <= 2'b00;
    end else if (ce) begin
      stb_s1_r <= fwd_frame_strobe;
      stb_s2_r <= stb_s1_r;
      stb_s3_r <= stb_s2_r;
    end
  end

  // R13: sample once per 1, 2 or 5 frames
  // R11: four values per port, held between samples
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < GOFM_NPORT; p++) begin
        fwd_hold_r[p] <= 4'h0;
        frame_cnt_r[p] <= 3'h0;
      end
    end else if (ce) begin
      for (int p = 0; p < GOFM_NPORT; p++) begin
        if (stb_s2_r[p] && !stb_s3_r[p]) begin
          if (frame_cnt_r[p] + 3'h1 >= frames_per_sample(link_cnt_r[p])) begin
            frame_cnt_r[p] <= 3'h0;
            // Stages two and three agree, value is stable
            if (fwd_s2_r[p] == fwd_s3_r[p]) begin
              fwd_hold_r[p] <= fwd_s3_r[p];
            end
          end else begin
            frame_cnt_r[p] <= frame_cnt_r[p] + 3'h1;
          end
        end
      end
    end
  end

  always_comb begin
    logic [7:0] c;
    logic [2:0] src;
    logic [2:0] fun;
    c = 8'h00;
    src = 3'h0;
    fun = 3'h0;
    pin_val = '0;
    pin_drv = '0;
    for (int i = 0; i < GOFM_NPIN; i++) begin
      c = cfg_flat[i*8 +: 8];
      src = c[GOFM_SRC_LSB +: 3];
      fun = c[GOFM_FUN_LSB +: 3];
      pin_drv[i] = 1'b1;
      unique case (src)
        // R17: port source, R12: any forward value
        GOFM_SRC_PORT0, GOFM_SRC_PORT1: begin
          unique case (fun)
            3'h0, 3'h1, 3'h2, 3'h3: pin_val[i] = fwd_hold_r[src[0]][fun[1:0]];
            3'h4: pin_val[i] = port_lock[src[0]];
            3'h5: pin_val[i] = port_pass[src[0]];
            3'h6: pin_val[i] = port_frame_valid[src[0]];
            3'h7: pin_val[i] = port_line_valid[src[0]];
          endcase
        end
        GOFM_SRC_DEV: begin
          unique case (fun)
            // R01: static level
            3'h0: pin_val[i] = c[GOFM_VAL_BIT];
            // R02: lock combine
            3'h1: pin_val[i] = |(port_lock & port_en_r);
            3'h2: pin_val[i] = and_enabled(port_lock, port_en_r);
            // R03: pass combine
            3'h3: pin_val[i] = and_enabled(port_pass, port_en_r);
            // R04: frame sync
            3'h4: pin_val[i] = frame_sync_pulse;
            // R05: interrupt polarity
            3'h5: pin_val[i] = dev_irq;
            3'h6: pin_val[i] = !dev_irq;
            3'h7: pin_drv[i] = 1'b0;
          endcase
        end
        GOFM_SRC_CSI: begin
          unique case (fun)
            // R06: pass combine
            3'h0: pin_val[i] = and_enabled(port_pass, port_en_r);
            3'h1: pin_val[i] = |(port_pass & port_en_r);
            // R07: recovered valids
            3'h2: pin_val[i] = csi_frame_valid;
            3'h3: pin_val[i] = csi_line_valid;
            // R08: ports synced
            3'h4: pin_val[i] = ports_synced;
            // R09: csi interrupt
            3'h5: pin_val[i] = csi_irq;
            3'h6, 3'h7: pin_drv[i] = 1'b0;
          endcase
        end
        // R20: reserved sources undriven
        default: pin_drv[i] = 1'b0;
      endcase
      // R18: drive enable gate
      pin_drv[i] = pin_drv[i] && c[GOFM_EN_BIT];
      if (!pin_drv[i]) begin
        pin_val[i] = 1'b0;
      end
    end
  end

  // R14: output register is the fifth pclk stage, forward latency at least 500 ns, above 225 ns
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpio_out <= '0;
      gpio_oe_n <= '1;
    end else if (ce) begin
      gpio_out <= pin_val;
      gpio_oe_n <= ~pin_drv;
    end
  end

  // Assertions
  drive_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // R18
    ce && !cfg_flat[GOFM_EN_BIT] |=> gpio_oe_n[0])
    else $error("pin 0 driven with enable low");

  static_level_a: assert property (@(posedge pclk) disable iff (!presetn) // R01
    ce && (cfg_flat[7:0] == 8'h11 || cfg_flat[7:0] == 8'h13)
    |=> !gpio_oe_n[0] && gpio_out[0] == $past(cfg_flat[GOFM_VAL_BIT]))
    else $error("static level not driven");

  lock_or_a: assert property (@(posedge pclk) disable iff (!presetn) // R02
    ce && cfg_flat[7:0] == 8'h31 |=> gpio_out[0] == $past(|(port_lock & port_en_r)))
    else $error("lock or wrong");

  pass_and_a: assert property (@(posedge pclk) disable iff (!presetn) // R03
    ce && cfg_flat[7:0] == 8'h71 |=> gpio_out[0] == $past(and_enabled(port_pass, port_en_r)))
    else $error("pass and wrong");

  sync_out_a: assert property (@(posedge pclk) disable iff (!presetn) // R04
    ce && cfg_flat[7:0] == 8'h91 |=> gpio_out[0] == $past(frame_sync_pulse))
    else $error("frame sync not routed");

  irq_low_a: assert property (@(posedge pclk) disable iff (!presetn) // R05
    ce && cfg_flat[7:0] == 8'hD1 |=> gpio_out[0] != $past(dev_irq))
    else $error("interrupt not inverted");

  csi_irq_a: assert property (@(posedge pclk) disable iff (!presetn) // R09
    ce && cfg_flat[15:8] == 8'hB5 |=> gpio_out[1] == $past(csi_irq))
    else $error("csi interrupt not routed");

  reserved_src_a: assert property (@(posedge pclk) disable iff (!presetn) // R20
    ce && cfg_flat[4*8+GOFM_SRC_LSB+1] |=> gpio_oe_n[4])
    else $error("reserved source drives pin");

  sequence apb_setup_s;
    psel && !penable && state_r == GOFM_IDLE && ce;
  endsequence
  apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn) // pready one edge after access
    apb_setup_s ##1 (psel && penable && ce) |=> pready)
    else $error("apb answer late");
endmodule

// ==== gofm_fwd_model.sv ====
`timescale 1ns/100ps
module gofm_fwd_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] val_p0,
  input wire logic [3:0] val_p1,
  output logic [3:0] fwd_gpio_p0,
  output logic [3:0] fwd_gpio_p1,
  output logic [1:0] fwd_frame_strobe
);
  logic [3:0] frame_cnt_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_cnt_r <= 4'h0;
    end else begin
      frame_cnt_r <= frame_cnt_r + 4'h1;
    end
  end
  // Port 1 frames offset by half a frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_frame_strobe <= 2'h0;
    end else begin
      fwd_frame_strobe <= {frame_cnt_r[3:2] == 2'h2, frame_cnt_r[3:2] == 2'h0};
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_gpio_p0 <= 4'h0;
      fwd_gpio_p1 <= 4'h0;
    end else begin
      fwd_gpio_p0 <= val_p0;
      fwd_gpio_p1 <= val_p1;
    end
  end
endmodule

// ==== gofm_output_function_mux_tb_top.sv ====
`timescale 1ns/100ps
module gofm_output_function_mux_tb_top
  import gofm_pkg::*;
;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, frame_sync_pulse = 0, dev_irq = 0;
  logic csi_frame_valid = 0, csi_line_valid = 0, ports_synced = 0, csi_irq = 0;
  logic [1:0] port_lock = 0, port_pass = 0, port_frame_valid = 0, port_line_valid = 0;
  logic [1:0] fwd_frame_strobe, en_m = 2'h3;
  logic [3:0] fwd_gpio_p0, fwd_gpio_p1, v0 = 4'h0, v1 = 4'h0;
  logic [GOFM_NPIN-1:0] gpio_out, gpio_oe_n;
  int n_errors = 0, comparisons = 0, rises = 0;
  logic st_d = 0;
  always #50 pclk = ~pclk;
  always @(posedge pclk) begin
    st_d <= fwd_frame_strobe[0];
    if (fwd_frame_strobe[0] && !st_d) rises <= rises + 1;
  end
  gofm_top dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .fwd_gpio_p0, .fwd_gpio_p1, .fwd_frame_strobe, .port_lock, .port_pass, .port_frame_valid,
    .port_line_valid, .frame_sync_pulse, .dev_irq, .csi_frame_valid, .csi_line_valid, .ports_synced,
    .csi_irq, .gpio_out, .gpio_oe_n);
  gofm_fwd_model ser (.pclk, .presetn, .val_p0(v0), .val_p1(v1), .fwd_gpio_p0, .fwd_gpio_p1,
    .fwd_frame_strobe);
  task wrap_up;
    if (n_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task bad(input string m);
    n_errors++;
    $display("ERROR %0t %s", $time, m);
    wrap_up;
  endtask
  task chk32(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task chk_pin(input int i, input logic oen, input logic v);
    comparisons++;
    if (gpio_oe_n[i] !== oen || gpio_out[i] !== v) begin
      n_errors++;
      $display("ERROR %0t pin %0d oe_n %b out %b", $time, i, gpio_oe_n[i], gpio_out[i]);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    int n;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) bad("no pready");
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    // Idle edge keeps the next setup from reassigning psel now
    @(posedge pclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1, a, d, r, e);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(0, a, 32'h0, r, e);
    chk32(r, x);
    chk32({31'h0, e}, {31'h0, xe});
  endtask
  task wcfg(input int i, input logic [2:0] f, input logic [2:0] s, input logic v, input logic en);
    logic [7:0] a;
    a = GOFM_PIN_CFG_BASE + 8'(i);
    // input enable taken as already cleared
    wr(a, {24'h0, f, s, v, en});
    repeat (3) @(posedge pclk);
  endtask
  task wait_pin(input int i, input logic v);
    int n;
    for (n = 0; n < 400 && (gpio_out[i] !== v || gpio_oe_n[i] !== 1'b0); n++) @(posedge pclk);
    if (n == 400) bad("pin wait expired");
  endtask
  task frames(input int k);
    int t, n;
    t = rises + k;
    for (n = 0; n < 2000 && rises < t; n++) @(posedge pclk);
    if (n == 2000) bad("frame wait expired");
  endtask
  task t_reset;
    chk32({25'h0, gpio_oe_n}, 32'h7F);
    chk32({25'h0, gpio_out}, 32'h0);
    rd(GOFM_LINK_CNT0_ADDR, 32'h1, 0);
    rd(GOFM_LINK_CNT1_ADDR, 32'h1, 0);
    rd(GOFM_PORT_EN_ADDR, 32'h3, 0);
    rd(GOFM_PIN_CFG_LAST, 32'h0, 0);
    wr(8'h80, 32'hFFFFFFFF);
    rd(8'h80, 32'h0, 1);
    wr(GOFM_PIN_CFG_BASE, 32'hFFFFFFAB);
    rd(GOFM_PIN_CFG_BASE, 32'hAB, 0);
  endtask
  task t_static;
    for (int i = 0; i < GOFM_NPIN; i++) wcfg(i, 3'h0, GOFM_SRC_DEV, i[0], 1);
    for (int i = 0; i < GOFM_NPIN; i++) chk_pin(i, 0, i[0]);
    rd(GOFM_PIN_STAT_ADDR, 32'h7F2A, 0);
    for (int i = 0; i < GOFM_NPIN; i++) wcfg(i, 3'h0, GOFM_SRC_DEV, 1, 0);
    for (int i = 0; i < GOFM_NPIN; i++) chk_pin(i, 1, 0);
  endtask
  task t_dev;
    logic x;
    for (int k = 0; k < 2; k++) begin
      en_m = k ? 2'h3 : 2'h1;
      wr(GOFM_PORT_EN_ADDR, {30'h0, en_m});
      port_lock <= 2'h1;
      port_pass <= k ? 2'h3 : 2'h2;
      frame_sync_pulse <= k[0];
      dev_irq <= k[0];
      for (int f = 1; f < 7; f++) begin
        wcfg(0, 3'(f), GOFM_SRC_DEV, 0, 1);
        case (f)
          1: x = |(port_lock & en_m);
          2: x = &(port_lock | ~en_m);
          3: x = &(port_pass | ~en_m);
          4: x = frame_sync_pulse;
          5: x = dev_irq;
          default: x = !dev_irq;
        endcase
        chk_pin(0, 0, x);
      end
    end
  endtask
  task t_csi;
    logic x;
    for (int k = 0; k < 2; k++) begin
      port_pass <= k ? 2'h0 : 2'h2;
      csi_frame_valid <= !k[0];
      csi_line_valid <= k[0];
      ports_synced <= !k[0];
      csi_irq <= k[0];
      for (int f = 0; f < 6; f++) begin
        wcfg(1, 3'(f), GOFM_SRC_CSI, 0, 1);
        case (f)
          0: x = &(port_pass | ~en_m);
          1: x = |(port_pass & en_m);
          2: x = csi_frame_valid;
          3: x = csi_line_valid;
          4: x = ports_synced;
          default: x = csi_irq;
        endcase
        chk_pin(1, 0, x);
      end
    end
  endtask
  task t_port;
    logic [7:0] sig;
    port_lock <= 2'h1;
    port_pass <= 2'h2;
    port_frame_valid <= 2'h1;
    port_line_valid <= 2'h2;
    sig = 8'b10011001;
    for (int p = 0; p < 2; p++) begin
      for (int f = 4; f < 8; f++) begin
        wcfg(2, 3'(f), 3'(p), 0, 1);
        chk_pin(2, 0, sig[7 - 2 * (f - 4) - p]);
      end
    end
  endtask
  task t_resv;
    logic [2:0] s [3] = '{3'h2, 3'h6, 3'h7};
    for (int j = 0; j < 3; j++) begin
      wcfg(4, 3'h7, s[j], 1, 1);
      chk_pin(4, 1, 0);
    end
    wcfg(4, 3'h7, GOFM_SRC_DEV, 1, 1);
    chk_pin(4, 1, 0);
    for (int f = 6; f < 8; f++) begin
      wcfg(4, 3'(f), GOFM_SRC_CSI, 1, 1);
      chk_pin(4, 1, 0);
    end
  endtask
  task t_rate(input logic [2:0] c, input logic [2:0] p);
    logic nv;
    int s;
    wr(GOFM_LINK_CNT0_ADDR, {29'h0, c});
    wcfg(3, 3'h1, GOFM_SRC_PORT0, 0, 1);
    nv = !v0[1];
    v0[1] <= nv;
    wait_pin(3, nv);
    // Hold four sampling periods before the next change
    frames(4 * int'(p));
    repeat (8) @(posedge pclk);
    s = rises;
    nv = !nv;
    v0[1] <= nv;
    wait_pin(3, nv);
    chk32(32'(rises - s), {29'h0, p});
  endtask
  task t_route;
    wcfg(6, 3'h2, GOFM_SRC_PORT1, 0, 1);
    v1 <= 4'h4;
    wait_pin(6, 1);
    v1 <= 4'hB;
    wait_pin(6, 0);
    chk_pin(6, 0, 0);
  endtask
  task t_hold;
    wcfg(5, 3'h5, GOFM_SRC_DEV, 0, 1);
    dev_irq <= 1'b0;
    repeat (2) @(posedge pclk);
    chk_pin(5, 0, 0);
    ce <= 1'b0;
    dev_irq <= 1'b1;
    repeat (4) @(posedge pclk);
    chk_pin(5, 0, 0);
    ce <= 1'b1;
    repeat (2) @(posedge pclk);
    chk_pin(5, 0, 1);
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_reset;
    t_static;
    t_dev;
    t_csi;
    t_port;
    t_resv;
    t_rate(3'h0, GOFM_FRAMES_ONE);
    t_rate(3'h1, GOFM_FRAMES_ONE);
    t_rate(3'h2, GOFM_FRAMES_TWO);
    t_rate(3'h3, GOFM_FRAMES_MANY);
    t_rate(3'h4, GOFM_FRAMES_MANY);
    t_route;
    t_hold;
    wrap_up;
  end
endmodule
